// ==== udl_adc_hold.sv ====
`timescale 1ns/100ps
module udl_adc_hold
    import udl_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic adc_valid,
    input wire logic [15:0] adc_plus_sample,
    input wire logic [15:0] adc_minus_sample,
    udl_adc_if.holder adc
);
    logic [15:0] plus_value_r;
    logic [15:0] minus_value_r;
    logic [7:0] plus_shadow_r;
    logic [7:0] minus_shadow_r;

    // out-of-range conversions saturate so software never sees a value past full scale
    function automatic logic [15:0] udl_clamp(input logic [15:0] v);
        udl_clamp = (v > UDL_READING_MAX_MV) ? UDL_READING_MAX_MV : v;
    endfunction

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            plus_value_r <= UDL_READING_RESET;
            minus_value_r <= UDL_READING_RESET;
        end else if (adc_valid) begin
            plus_value_r <= udl_clamp(adc_plus_sample);
            minus_value_r <= udl_clamp(adc_minus_sample);
        end
    end

    // low byte frozen when the high byte is read, so a two-byte read is coherent
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            plus_shadow_r <= 8'h00;
            minus_shadow_r <= 8'h00;
        end else begin
            if (adc.snap_plus) begin
                plus_shadow_r <= plus_value_r[7:0];
            end
            if (adc.snap_minus) begin
                minus_shadow_r <= minus_value_r[7:0];
            end
        end
    end

    assign adc.plus_value = plus_value_r;
    assign adc.minus_value = minus_value_r;
    assign adc.plus_low_shadow = plus_shadow_r;
    assign adc.minus_low_shadow = minus_shadow_r;

    property p_reading_in_range;
        @(posedge clk) disable iff (!resetn)
        (plus_value_r <= UDL_READING_MAX_MV) && (minus_value_r <= UDL_READING_MAX_MV);
    endproperty
    a_reading_in_range: assert property (p_reading_in_range)
        else $error("line voltage reading beyond full scale");

    property p_reading_tracks_sample;
        @(posedge clk) disable iff (!resetn)
        adc_valid && (adc_plus_sample <= UDL_READING_MAX_MV) |=> plus_value_r == $past(adc_plus_sample);
    endproperty
    a_reading_tracks_sample: assert property (p_reading_tracks_sample)
        else $error("plus line reading not one count per millivolt");
endmodule

// ==== udl_adc_if.sv ====
`timescale 1ns/100ps
interface udl_adc_if;
    logic [15:0] plus_value;
    logic [15:0] minus_value;
    logic [7:0] plus_low_shadow;
    logic [7:0] minus_low_shadow;
    logic snap_plus;
    logic snap_minus;
    modport holder (
        output plus_value,
        output minus_value,
        output plus_low_shadow,
        output minus_low_shadow,
        input snap_plus,
        input snap_minus
    );
    modport regs (
        input plus_value,
        input minus_value,
        input plus_low_shadow,
        input minus_low_shadow,
        output snap_plus,
        output snap_minus
    );
endinterface

// ==== udl_host_model.sv ====
`timescale 1ns/100ps
module udl_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wr_data
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wr_data = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        // scramble data once released so a stale byte cannot pass for a held one
        reg_wr_data <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk);
            if (reg_rd_valid === 1'b1) begin
                ok = 1'b1;
                d = reg_rd_data;
            end
        end
    endtask
    // two reads on consecutive edges, the strobe held high across both
    task automatic rd2(input logic [7:0] a0, input logic [7:0] a1, output logic [7:0] d0,
                       output logic [7:0] d1, output bit ok);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a0;
        @(posedge clk);
        reg_addr <= a1;
        @(negedge clk);
        ok = (reg_rd_valid === 1'b1);
        d0 = reg_rd_data;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        @(negedge clk);
        ok = ok && (reg_rd_valid === 1'b1);
        d1 = reg_rd_data;
    endtask
endmodule

// ==== udl_line_regs.sv ====
`timescale 1ns/100ps
// Summary of operation
// - plus and minus line voltages read as 16-bit millivolt counts, 0-3600, reset zero
// - 3-bit drive codes select hi-z, ground or 0.6-3.3 V; plus code 7 shorts lines
// - part information is read-only; top two bits reserved, low six hold two fields
// - fixed revision code sits in bits 5 to 3
// - fixed part-number code sits in bits 2 to 0
module udl_line_regs
    import udl_pkg::*;
#(
    parameter logic [2:0] SILICON_REVISION_CODE = 3'h2, // arbitrary value
    parameter logic [2:0] PART_NUMBER_CODE = 3'h5 // arbitrary value
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    input wire logic adc_valid,
    input wire logic [15:0] adc_plus_sample,
    input wire logic [15:0] adc_minus_sample,
    output logic [2:0] plus_line_drive_level,
    output logic [2:0] minus_line_drive_level,
    output logic lines_shorted
);
    udl_adc_if adc ();

    logic [7:0] drive_ctrl_r;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic rd_valid_r;
    logic [7:0] part_info;
    logic [2:0] plus_code;
    logic [2:0] minus_code;

    udl_adc_hold u_hold (
        .clk(clk),
        .resetn(resetn),
        .adc_valid(adc_valid),
        .adc_plus_sample(adc_plus_sample),
        .adc_minus_sample(adc_minus_sample),
        .adc(adc)
    );

    // reading the high byte freezes the matching low byte
    assign adc.snap_plus = reg_rd_en && (reg_addr == UDL_OFS_PLUS_HI);
    assign adc.snap_minus = reg_rd_en && (reg_addr == UDL_OFS_MINUS_HI);

    // reserved bits 1:0 are kept as written; the field is read/write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drive_ctrl_r <= UDL_DRIVE_RESET;
        end else if (reg_wr_en && (reg_addr == UDL_OFS_DRIVE)) begin
            drive_ctrl_r <= reg_wr_data;
        end
    end

    // revision in 5:3, part number in 2:0; the bit figure shows them swapped
    assign part_info = {2'b00, SILICON_REVISION_CODE, PART_NUMBER_CODE};

    assign plus_code = drive_ctrl_r[UDL_PLUS_LSB +: 3];
    assign minus_code = drive_ctrl_r[UDL_MINUS_LSB +: 3];

    // plus code 7 shorts the lines: the plus side goes to hi-z, the minus side keeps following its own code
    always_comb begin
        lines_shorted = 1'b0;
        plus_line_drive_level = plus_code;
        minus_line_drive_level = minus_code;
        case (udl_drive_e'(plus_code))
            UDL_DRV_SHORT: begin
                lines_shorted = 1'b1;
                plus_line_drive_level = UDL_DRV_HIZ;
            end
            default: begin
                lines_shorted = 1'b0;
            end
        endcase
        // the reserved minus code is treated as high impedance
        if (minus_code == UDL_DRV_SHORT) begin
            minus_line_drive_level = UDL_DRV_HIZ;
        end
    end

    // writes to read-only offsets are dropped; unmapped reads return zero
    always_comb begin
        case (reg_addr)
            UDL_OFS_PLUS_HI: rd_data_nxt = adc.plus_value[15:8];
            UDL_OFS_PLUS_LO: rd_data_nxt = adc.plus_low_shadow;
            UDL_OFS_MINUS_HI: rd_data_nxt = adc.minus_value[15:8];
            UDL_OFS_MINUS_LO: rd_data_nxt = adc.minus_low_shadow;
            UDL_OFS_DRIVE: rd_data_nxt = drive_ctrl_r;
            UDL_OFS_PART: rd_data_nxt = part_info;
            default: rd_data_nxt = UDL_UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= reg_rd_en;
            if (reg_rd_en) begin
                rd_data_r <= rd_data_nxt;
            end
        end
    end

    assign reg_rd_data = rd_data_r;
    assign reg_rd_valid = rd_valid_r;

    property p_short_follows_plus_code;
        @(posedge clk) disable iff (!resetn)
        reg_wr_en && (reg_addr == UDL_OFS_DRIVE) |=>
            (lines_shorted == ($past(reg_wr_data[7:5]) == 3'h7))
            && (plus_line_drive_level == (lines_shorted ? 3'h0 : $past(reg_wr_data[7:5])));
    endproperty
    a_short_follows_plus_code: assert property (p_short_follows_plus_code)
        else $error("plus drive code not applied after write");

    property p_minus_reserved_hiz;
        @(posedge clk) disable iff (!resetn)
        (drive_ctrl_r[4:2] == 3'h7) |-> (minus_line_drive_level == 3'h0);
    endproperty
    a_minus_reserved_hiz: assert property (p_minus_reserved_hiz)
        else $error("reserved minus code drove a level");

    property p_part_read_only;
        @(posedge clk) disable iff (!resetn)
        reg_rd_en && (reg_addr == UDL_OFS_PART) ##1 reg_rd_en && (reg_addr == UDL_OFS_PART)
            |=> rd_valid_r && (rd_data_r[7:6] == 2'b00) && $stable(rd_data_r);
    endproperty
    a_part_read_only: assert property (p_part_read_only)
        else $error("part information changed or reserved bits set");

    property p_revision_field;
        @(posedge clk) disable iff (!resetn)
        reg_rd_en && (reg_addr == UDL_OFS_PART) |=> rd_data_r[5:3] == SILICON_REVISION_CODE;
    endproperty
    a_revision_field: assert property (p_revision_field)
        else $error("revision code not in bits 5 to 3");

    property p_part_number_field;
        @(posedge clk) disable iff (!resetn)
        reg_rd_en && (reg_addr == UDL_OFS_PART) |=> rd_data_r[2:0] == PART_NUMBER_CODE;
    endproperty
    a_part_number_field: assert property (p_part_number_field)
        else $error("part-number code not in bits 2 to 0");

    property p_minus_read_coherent;
        @(posedge clk) disable iff (!resetn)
        reg_rd_en && (reg_addr == UDL_OFS_MINUS_HI) ##1 reg_rd_en && (reg_addr == UDL_OFS_MINUS_LO)
            |=> rd_data_r == $past(adc.minus_value[7:0], 2);
    endproperty
    a_minus_read_coherent: assert property (p_minus_read_coherent)
        else $error("minus line low byte not from the same reading");

    property p_plus_read_coherent;
        @(posedge clk) disable iff (!resetn)
        reg_rd_en && (reg_addr == UDL_OFS_PLUS_HI) ##1 reg_rd_en && (reg_addr == UDL_OFS_PLUS_LO)
            |=> rd_data_r == $past(adc.plus_value[7:0], 2);
    endproperty
    a_plus_read_coherent: assert property (p_plus_read_coherent)
        else $error("plus line low byte not from the same reading");

    property p_plus_high_read;
        @(posedge clk) disable iff (!resetn)
        reg_rd_en && (reg_addr == UDL_OFS_PLUS_HI) |=> rd_data_r == $past(adc.plus_value[15:8]);
    endproperty
    a_plus_high_read: assert property (p_plus_high_read)
        else $error("plus line high byte not returned");

    property p_minus_high_read;
        @(posedge clk) disable iff (!resetn)
        reg_rd_en && (reg_addr == UDL_OFS_MINUS_HI) |=> rd_data_r == $past(adc.minus_value[15:8]);
    endproperty
    a_minus_high_read: assert property (p_minus_high_read)
        else $error("minus line high byte not returned");

    property p_rd_valid_pulse;
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> (rd_valid_r == $past(reg_rd_en));
    endproperty
    a_rd_valid_pulse: assert property (p_rd_valid_pulse)
        else $error("read valid not one cycle after the read strobe");

    property p_drive_write_lands;
        @(posedge clk) disable iff (!resetn)
        reg_wr_en && (reg_addr == UDL_OFS_DRIVE) |=> drive_ctrl_r == $past(reg_wr_data);
    endproperty
    a_drive_write_lands: assert property (p_drive_write_lands)
        else $error("drive control write not stored");

    property p_drive_held;
        @(posedge clk) disable iff (!resetn)
        !(reg_wr_en && (reg_addr == UDL_OFS_DRIVE)) |=> $stable(drive_ctrl_r);
    endproperty
    a_drive_held: assert property (p_drive_held)
        else $error("drive control changed without a write to it");

    property p_minus_level_follows;
        @(posedge clk) disable iff (!resetn)
        (drive_ctrl_r[4:2] != 3'h7) |-> (minus_line_drive_level == drive_ctrl_r[4:2]);
    endproperty
    a_minus_level_follows: assert property (p_minus_level_follows)
        else $error("minus drive level differs from its code");

    property p_cov_short;
        @(posedge clk) disable iff (!resetn) lines_shorted;
    endproperty
    c_cov_short: cover property (p_cov_short);

    property p_cov_reading_read;
        @(posedge clk) disable iff (!resetn)
        reg_rd_en && (reg_addr == UDL_OFS_PLUS_HI) ##1 reg_rd_en && (reg_addr == UDL_OFS_PLUS_LO);
    endproperty
    c_cov_reading_read: cover property (p_cov_reading_read);

    property p_cov_drive_3v3;
        @(posedge clk) disable iff (!resetn)
        (plus_line_drive_level == 3'h6) && (minus_line_drive_level == 3'h2);
    endproperty
    c_cov_drive_3v3: cover property (p_cov_drive_3v3);

    property p_cov_minus_reserved;
        @(posedge clk) disable iff (!resetn) drive_ctrl_r[4:2] == 3'h7;
    endproperty
    c_cov_minus_reserved: cover property (p_cov_minus_reserved);
endmodule

// ==== udl_pkg.sv ====
package udl_pkg;
    localparam int UDL_DATA_W = 16;
    localparam int UDL_ADDR_W = 8;
    // byte offsets; each 16-bit reading spans two offsets, high byte first
    localparam logic [7:0] UDL_OFS_PLUS_HI = 8'h43;
    localparam logic [7:0] UDL_OFS_PLUS_LO = 8'h44;
    localparam logic [7:0] UDL_OFS_MINUS_HI = 8'h45;
    localparam logic [7:0] UDL_OFS_MINUS_LO = 8'h46;
    localparam logic [7:0] UDL_OFS_DRIVE = 8'h47;
    localparam logic [7:0] UDL_OFS_PART = 8'h48;
    // line-drive control field layout
    localparam int UDL_PLUS_LSB = 5;
    localparam int UDL_MINUS_LSB = 2;
    localparam int UDL_DRV_RSVD_LSB = 0;
    localparam logic [7:0] UDL_DRIVE_RESET = 8'h00;
    // part-information field layout
    localparam int UDL_REV_LSB = 3;
    localparam int UDL_PN_LSB = 0;
    // reading scale: one count per millivolt, zero offset
    localparam logic [15:0] UDL_READING_MAX_MV = 16'h0E10;
    localparam logic [15:0] UDL_READING_RESET = 16'h0000;
    localparam logic [7:0] UDL_UNMAPPED_READ = 8'h00;
    typedef enum logic [2:0] {
        UDL_DRV_HIZ,
        UDL_DRV_GND,
        UDL_DRV_0V6,
        UDL_DRV_1V2,
        UDL_DRV_2V0,
        UDL_DRV_2V7,
        UDL_DRV_3V3,
        UDL_DRV_SHORT
    } udl_drive_e;
endpackage

// ==== usb_data_line_adc_drive_regs_tb.sv ====
`timescale 1ns/100ps
module usb_data_line_adc_drive_regs_tb;
    import udl_pkg::*;
    localparam logic [2:0] REV = 3'h3; // arbitrary value
    localparam logic [2:0] PN = 3'h6; // arbitrary value
    logic clk, resetn, adc_valid, wr_en, rd_en, rd_valid, shorted;
    logic [7:0] addr, wr_data, rd_data;
    logic [15:0] plus_s, minus_s;
    logic [2:0] plus_lvl, minus_lvl;
    logic [31:0] seed = 32'h00010768;
    int bad_count, checks, plus_mv, minus_mv, old_mv;
    udl_line_regs #(.SILICON_REVISION_CODE(REV), .PART_NUMBER_CODE(PN)) i_udl_line_regs (
        .clk(clk), .resetn(resetn), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wr_data(wr_data), .reg_rd_data(rd_data),
        .reg_rd_valid(rd_valid), .adc_valid(adc_valid), .adc_plus_sample(plus_s),
        .adc_minus_sample(minus_s), .plus_line_drive_level(plus_lvl),
        .minus_line_drive_level(minus_lvl), .lines_shorted(shorted));
    udl_host_model i_udl_host_model (
        .clk(clk), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wr_data));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed[15:0]);
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(logic [7:0] a, logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        i_udl_host_model.rd(a, d, ok);
        if (!ok) begin
            bad_count++;
            test_done();
        end
        check($sformatf("read %h", a), {8'h00, d}, {8'h00, exp});
    endtask
    task automatic rchk2(logic [7:0] a0, logic [7:0] a1, logic [7:0] e0, logic [7:0] e1);
        logic [7:0] d0, d1;
        bit ok;
        i_udl_host_model.rd2(a0, a1, d0, d1, ok);
        if (!ok) begin
            bad_count++;
            test_done();
        end
        check($sformatf("read %h", a0), {8'h00, d0}, {8'h00, e0});
        check($sformatf("read %h", a1), {8'h00, d1}, {8'h00, e1});
    endtask
    // readings are clamped at full scale, so the model saturates too
    task automatic adc_load(int p, int m);
        @(posedge clk);
        adc_valid <= 1'b1;
        plus_s <= p[15:0];
        minus_s <= m[15:0];
        @(posedge clk);
        adc_valid <= 1'b0;
        plus_mv = (p > 3600) ? 3600 : p;
        minus_mv = (m > 3600) ? 3600 : m;
    endtask
    task automatic adc_case(int p, int m);
        adc_load(p, m);
        rchk(8'h43, plus_mv[15:8]);
        rchk(8'h44, plus_mv[7:0]);
        rchk(8'h45, minus_mv[15:8]);
        rchk(8'h46, minus_mv[7:0]);
        rchk2(8'h43, 8'h44, plus_mv[15:8], plus_mv[7:0]);
        rchk2(8'h45, 8'h46, minus_mv[15:8], minus_mv[7:0]);
    endtask
    initial begin
        logic [7:0] d;
        resetn = 1'b0;
        adc_valid = 1'b0;
        plus_s = 16'h0000;
        minus_s = 16'h0000;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int a = 8'h43; a <= 8'h47; a++) rchk(a[7:0], 8'h00);
        rchk(8'h48, {2'b00, REV, PN});
        rchk(8'h50, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 64; i++) begin
            d = {i[5:0], i[1:0] ^ i[4:3]};
            i_udl_host_model.wr(8'h47, d);
            @(negedge clk);
            check("plus level", plus_lvl, (d[7:5] == 3'h7) ? 3'h0 : d[7:5]);
            check("minus level", minus_lvl, (d[4:2] == 3'h7) ? 3'h0 : d[4:2]);
            check("shorted", shorted, d[7:5] == 3'h7);
            rchk(8'h47, d);
        end
        $display("drive codes done");
        adc_case(3600, 3601);
        adc_case(0, 65535);
        repeat (6) adc_case(rnd() % 4200, rnd() % 4200);
        i_udl_host_model.wr(8'h48, 8'hFF);
        i_udl_host_model.wr(8'h43, 8'hFF);
        rchk(8'h48, {2'b00, REV, PN});
        rchk(8'h43, plus_mv[15:8]);
        rchk2(8'h48, 8'h48, {2'b00, REV, PN}, {2'b00, REV, PN});
        $display("readings done");
        // a new conversion after the high-byte read must not reach the low byte
        adc_case(1000, 2000);
        old_mv = plus_mv;
        adc_load(291, 0);
        rchk(8'h44, old_mv[7:0]);
        rchk(8'h43, plus_mv[15:8]);
        rchk(8'h44, plus_mv[7:0]);
        $display("snapshot done");
        i_udl_host_model.wr(8'h47, 8'hE4);
        @(posedge clk);
        resetn <= 1'b0;
        @(negedge clk);
        check("shorted", shorted, 1'b0);
        check("plus level", plus_lvl, 3'h0);
        check("minus level", minus_lvl, 3'h0);
        @(posedge clk);
        resetn <= 1'b1;
        rchk(8'h47, 8'h00);
        rchk2(8'h43, 8'h44, 8'h00, 8'h00);
        rchk2(8'h45, 8'h46, 8'h00, 8'h00);
        $display("mid-run reset done");
        test_done();
    end
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        test_done();
    end
endmodule
